// File: sram_burst_pkg.sv
// Shared constants for the burst SRAM link and its two ends
package sram_burst_pkg;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam int LANES = 2;
    localparam int BURST_LEN = 4;
    localparam int BURST_W = WORD_W * BURST_LEN;
    localparam int MASK_W = LANES * BURST_LEN;
    localparam int ADDR_W = 20;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_MHZ = 10;
    localparam int PLL_OFF_MAX_MHZ = 167;
    // Least half period of the link clock allowed with the PLL off
    localparam int K_HALF_MIN_RAW =
        (CLK_MHZ + 2 * PLL_OFF_MAX_MHZ - 1) / (2 * PLL_OFF_MAX_MHZ);
    localparam int K_HALF_MIN_CYCLES =
        (K_HALF_MIN_RAW < 1) ? 1 : K_HALF_MIN_RAW;
    // Half period of the link clock in system clocks
    localparam int K_HALF_CYCLES = 8;
    // Read latency in clock phase edges: 2.5 cycles and 1 cycle
    localparam int LAT_PLL_HALVES = 5;
    localparam int LAT_LEGACY_HALVES = 2;
    localparam logic [2:0] BEATS_AFTER_FIRST = 3'h3;
    localparam logic [2:0] BEATS_TOTAL = 3'h4;
    localparam logic [1:0] LAST_BEAT = 2'h3;
endpackage

// File: sram_link_if.sv
// Pin bundle between the memory controller and the burst SRAM
`timescale 1ns/1ns
interface sram_link_if #(
    parameter int AW = sram_burst_pkg::ADDR_W
) ();
    logic kClk;
    logic kClkN;
    logic pllDisableN;
    logic readPortSelectN;
    logic writePortSelectN;
    logic [sram_burst_pkg::LANES-1:0] byteLaneWriteMaskN;
    logic [AW-1:0] addr;
    logic [sram_burst_pkg::WORD_W-1:0] d;
    logic [sram_burst_pkg::WORD_W-1:0] q;
    logic qOeN;

    modport ctrl (
        output kClk,
        output kClkN,
        output pllDisableN,
        output readPortSelectN,
        output writePortSelectN,
        output byteLaneWriteMaskN,
        output addr,
        output d,
        input q,
        input qOeN
    );

    modport mem (
        input kClk,
        input kClkN,
        input pllDisableN,
        input readPortSelectN,
        input writePortSelectN,
        input byteLaneWriteMaskN,
        input addr,
        input d,
        output q,
        output qOeN
    );
endinterface

// File: burst_sram_device.sv
// Memory end: pin capture, port arbitration, array and read pipe
`timescale 1ns/1ns
// How it works
// - Low pllDisableN switches the PLL off
// - PLL off: controller stays slow, legacy timing
// - PLL on: first read word 2.5 cycles later
// - PLL off: first read word one cycle later
// - Every access moves four 18-bit words
// - Writes on d only, reads on q only
// - One shared address bus for both ports
// - Accesses start only on positive clock rise
// - Write data captured on both clock rises
// - Read data launched on both clock rises
// - Selects and lane masks registered on rises
// - Only rising edges of both clocks used
// - Back-to-back read request is ignored
// - Back-to-back write request is ignored
// - Port selects sampled on positive rise only
// - Both selected after idle: read wins
module burst_sram_device #(
    parameter int AW = sram_burst_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic nrst,
    sram_link_if.mem link,
    output logic pllEnabled
);
    localparam int WW = sram_burst_pkg::WORD_W;
    localparam int BW = sram_burst_pkg::BYTE_W;
    localparam int BL = sram_burst_pkg::BURST_LEN;
    localparam int LN = sram_burst_pkg::LANES;
    localparam int XW = sram_burst_pkg::BURST_W;
    localparam int MW = sram_burst_pkg::MASK_W;
    localparam int PD = sram_burst_pkg::LAT_PLL_HALVES;
    localparam int IW = 5 + LN + AW + WW;
    localparam logic [2:0] TAP_PLL =
        3'(sram_burst_pkg::LAT_PLL_HALVES - 1);
    localparam logic [2:0] TAP_LEGACY =
        3'(sram_burst_pkg::LAT_LEGACY_HALVES - 1);

    // Pin capture through two flops
    wire [IW-1:0] pins = {link.kClk, link.kClkN, link.pllDisableN,
        link.readPortSelectN, link.writePortSelectN,
        link.byteLaneWriteMaskN, link.addr, link.d};
    logic [IW-1:0] pinMeta;
    logic [IW-1:0] pinSync;
    logic kPrev;
    logic kNPrev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinMeta <= '1;
            pinSync <= '1;
            kPrev <= 1'h1;
            kNPrev <= 1'h1;
        end else begin
            pinMeta <= pins;
            pinSync <= pinMeta;
            kPrev <= pinSync[IW-1];
            kNPrev <= pinSync[IW-2];
        end
    end

    wire sK = pinSync[IW-1];
    wire sKN = pinSync[IW-2];
    wire sPllDisableN = pinSync[IW-3];
    wire sReadSelN = pinSync[IW-4];
    wire sWriteSelN = pinSync[IW-5];
    wire [LN-1:0] sLaneMaskN = pinSync[WW+AW +: LN];
    wire [AW-1:0] sAddr = pinSync[WW +: AW];
    wire [WW-1:0] sD = pinSync[WW-1:0];

    // Rising edges of each clock phase
    wire kRise = sK & ~kPrev;
    wire kbRise = sKN & ~kNPrev;
    wire edgeAny = kRise | kbRise;

    // Port arbitration on the positive clock rise
    logic prevRead;
    logic prevWrite;
    wire readGo = kRise & ~sReadSelN & ~prevRead;
    wire writeGo = kRise & ~sWriteSelN & ~prevWrite & ~readGo;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevRead <= 1'h0;
            prevWrite <= 1'h0;
        end else if (kRise) begin
            prevRead <= readGo;
            prevWrite <= writeGo;
        end
    end

    // Write burst capture
    logic wArm;
    logic [AW-1:0] wPendAddr;
    logic [AW-1:0] wCurAddr;
    logic [2:0] wCnt;
    logic [XW-1:0] wBuf;
    logic [MW-1:0] wEn;
    logic wCommit;
    logic [XW-1:0] mem [0:(1<<AW)-1];

    wire wStart = kRise & wArm;
    wire beatTake = edgeAny & (wStart | (wCnt != 3'h0));
    wire [2:0] beatRem = sram_burst_pkg::BEATS_TOTAL - wCnt;
    wire [1:0] beatIdx = wStart ? 2'h0 : beatRem[1:0];
    wire [XW-1:0] memOld = mem[wCurAddr];
    wire [XW-1:0] merged;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wArm <= 1'h0;
            wPendAddr <= '0;
            wCurAddr <= '0;
            wCnt <= 3'h0;
            wCommit <= 1'h0;
        end else begin
            wCommit <= beatTake & (beatIdx == sram_burst_pkg::LAST_BEAT);
            if (kRise) begin
                wArm <= writeGo;
            end
            if (writeGo) begin
                wPendAddr <= sAddr;
            end
            if (wStart) begin
                wCurAddr <= wPendAddr;
                wCnt <= sram_burst_pkg::BEATS_AFTER_FIRST;
            end else if (beatTake) begin
                wCnt <= wCnt - 3'h1;
            end
        end
    end

    // Byte lanes of the burst, masked per lane
    genvar j;
    generate
        for (j = 0; j < MW; j++) begin : gLane
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    wBuf[j*BW +: BW] <= '0;
                    wEn[j] <= 1'h0;
                end else if (beatTake && beatIdx == 2'(j / LN)) begin
                    wBuf[j*BW +: BW] <= sD[(j%LN)*BW +: BW];
                    wEn[j] <= ~sLaneMaskN[j%LN];
                end
            end
            assign merged[j*BW +: BW] =
                wEn[j] ? wBuf[j*BW +: BW] : memOld[j*BW +: BW];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (wCommit) begin
            mem[wCurAddr] <= merged;
        end
    end

    // Read latency pipe, one stage per clock phase edge
    logic [PD-1:0] pipeValid;
    logic [AW-1:0] pipeAddr [0:PD-1];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pipeValid[0] <= 1'h0;
            pipeAddr[0] <= '0;
        end else if (edgeAny) begin
            pipeValid[0] <= readGo;
            pipeAddr[0] <= sAddr;
        end
    end

    genvar s;
    generate
        for (s = 1; s < PD; s++) begin : gStage
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    pipeValid[s] <= 1'h0;
                    pipeAddr[s] <= '0;
                end else if (edgeAny) begin
                    pipeValid[s] <= pipeValid[s-1];
                    pipeAddr[s] <= pipeAddr[s-1];
                end
            end
        end
    endgenerate

    wire [2:0] tapIdx = pllEnabled ? TAP_PLL : TAP_LEGACY;
    wire launch = edgeAny & pipeValid[tapIdx];
    wire [XW-1:0] rdWord = mem[pipeAddr[tapIdx]];

    // Read burst output
    logic [XW-1:0] rBuf;
    logic [2:0] rCnt;
    wire [2:0] rRem = sram_burst_pkg::BEATS_TOTAL - rCnt;
    wire [WW-1:0] rNext = rBuf[WW*rRem[1:0] +: WW];
    wire readIdle = (pipeValid == '0) & (rCnt == 3'h0) & ~launch;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rBuf <= '0;
            rCnt <= 3'h0;
            link.q <= '0;
            link.qOeN <= 1'h1;
        end else if (launch) begin
            rBuf <= rdWord;
            rCnt <= sram_burst_pkg::BEATS_AFTER_FIRST;
            link.q <= rdWord[WW-1:0];
            link.qOeN <= 1'h0;
        end else if (edgeAny && rCnt != 3'h0) begin
            rCnt <= rCnt - 3'h1;
            link.q <= rNext;
        end else if (edgeAny) begin
            link.qOeN <= 1'h1;
        end
    end

    // Latency mode follows the pin only while no read is in flight
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pllEnabled <= 1'h1;
        end else if (readIdle) begin
            pllEnabled <= sPllDisableN;
        end
    end
endmodule

// File: burst_sram_ctrl.sv
// Controller end: request FIFO, link clock divider, burst sequencing
`timescale 1ns/1ns
module sync_fifo #(
    parameter int W = 8,
    parameter int DEPTH = sram_burst_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    wire [PW:0] next_count = count + {{PW{1'h0}}, push}
        - {{PW{1'h0}}, pop};

    assign outData = store[rdPtr];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'h1;
            outValid <= 1'h0;
        end else begin
            wrPtr <= push ? PW'(wrPtr + 1'h1) : wrPtr;
            rdPtr <= pop ? PW'(rdPtr + 1'h1) : rdPtr;
            count <= next_count;
            inReady <= next_count != (PW+1)'(DEPTH);
            outValid <= next_count != '0;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end
endmodule

module burst_sram_ctrl #(
    parameter int AW = sram_burst_pkg::ADDR_W,
    parameter int HALF = sram_burst_pkg::K_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    sram_link_if.ctrl link,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [AW-1:0] reqAddr,
    input wire logic [sram_burst_pkg::BURST_W-1:0] reqData,
    input wire logic [sram_burst_pkg::MASK_W-1:0] reqMask,
    input wire logic pllDisableN,
    output logic rspValid,
    output logic [sram_burst_pkg::BURST_W-1:0] rspData
);
    localparam int WW = sram_burst_pkg::WORD_W;
    localparam int XW = sram_burst_pkg::BURST_W;
    localparam int MW = sram_burst_pkg::MASK_W;
    localparam int LN = sram_burst_pkg::LANES;
    localparam int FW = 1 + AW + XW + MW;

    wire fifoValid;
    wire [FW-1:0] fifoOut;
    wire issue;

    sync_fifo #(.W(FW), .DEPTH(sram_burst_pkg::FIFO_DEPTH)) reqFifo (
        .clk(clk),
        .nrst(nrst),
        .inValid(reqValid),
        .inReady(reqReady),
        .inData({reqWrite, reqAddr, reqData, reqMask}),
        .outValid(fifoValid),
        .outReady(issue),
        .outData(fifoOut)
    );

    wire oWrite = fifoOut[FW-1];
    wire [AW-1:0] oAddr = fifoOut[XW+MW +: AW];
    wire [XW-1:0] oData = fifoOut[MW +: XW];
    wire [MW-1:0] oMask = fifoOut[MW-1:0];

    // Link clock pair, outputs change mid phase
    logic [7:0] divCnt;
    logic cmdTurn;
    wire halfEnd = divCnt == 8'(HALF - 1);
    wire prep = divCnt == 8'(HALF / 2 - 1);
    wire prepRise = prep & ~link.kClk;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divCnt <= 8'h00;
            link.kClk <= 1'h0;
            link.kClkN <= 1'h1;
            link.pllDisableN <= 1'h1;
        end else begin
            divCnt <= halfEnd ? 8'h00 : divCnt + 8'h01;
            link.pllDisableN <= pllDisableN;
            if (halfEnd) begin
                link.kClk <= ~link.kClk;
                link.kClkN <= link.kClk;
            end
        end
    end

    // Commands on every other positive rise
    assign issue = prepRise & cmdTurn & fifoValid;

    logic wArm;
    logic [2:0] wCnt;
    logic [XW-1:0] wPendData;
    logic [MW-1:0] wPendMask;
    logic [XW-1:0] wCurData;
    logic [MW-1:0] wCurMask;
    wire beatStart = prepRise & wArm;
    wire beatTake = prep & (beatStart | (wCnt != 3'h0));
    wire [2:0] beatRem = sram_burst_pkg::BEATS_TOTAL - wCnt;
    wire [1:0] beatIdx = beatStart ? 2'h0 : beatRem[1:0];
    wire [XW-1:0] srcData = beatStart ? wPendData : wCurData;
    wire [MW-1:0] srcMask = beatStart ? wPendMask : wCurMask;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmdTurn <= 1'h1;
            link.readPortSelectN <= 1'h1;
            link.writePortSelectN <= 1'h1;
            link.addr <= '0;
            wArm <= 1'h0;
            wPendData <= '0;
            wPendMask <= '0;
        end else if (prepRise) begin
            cmdTurn <= ~cmdTurn;
            link.readPortSelectN <= ~(issue & ~oWrite);
            link.writePortSelectN <= ~(issue & oWrite);
            link.addr <= issue ? oAddr : link.addr;
            wArm <= issue & oWrite;
            if (issue) begin
                wPendData <= oData;
                wPendMask <= oMask;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wCnt <= 3'h0;
            wCurData <= '0;
            wCurMask <= '0;
            link.d <= '0;
            link.byteLaneWriteMaskN <= '1;
        end else if (beatTake) begin
            wCnt <= beatStart ? sram_burst_pkg::BEATS_AFTER_FIRST
                : wCnt - 3'h1;
            wCurData <= srcData;
            wCurMask <= srcMask;
            link.d <= srcData[WW*beatIdx +: WW];
            link.byteLaneWriteMaskN <= ~srcMask[LN*beatIdx +: LN];
        end
    end

    // Read data capture through two flops
    logic [WW:0] qMeta;
    logic [WW:0] qSync;
    logic [XW-1:0] rdBuf;
    logic [1:0] rdCnt;
    wire rdTake = halfEnd & ~qSync[WW];
    wire [XW-1:0] rdShift = {qSync[WW-1:0], rdBuf[XW-1:WW]};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            qMeta <= {1'h1, {WW{1'h0}}};
            qSync <= {1'h1, {WW{1'h0}}};
            rdBuf <= '0;
            rdCnt <= 2'h0;
            rspValid <= 1'h0;
            rspData <= '0;
        end else begin
            qMeta <= {link.qOeN, link.q};
            qSync <= qMeta;
            rspValid <= rdTake & (rdCnt == sram_burst_pkg::LAST_BEAT);
            if (rdTake) begin
                rdBuf <= rdShift;
                rdCnt <= rdCnt + 2'h1;
            end
            if (rdTake && rdCnt == sram_burst_pkg::LAST_BEAT) begin
                rspData <= rdShift;
            end
        end
    end
endmodule

// File: burst_sram_link_sva.sv
// Link-level assertions for the burst SRAM pin bundle
`timescale 1ns/1ns
module burst_sram_link_sva #(
    parameter int AW = sram_burst_pkg::ADDR_W,
    parameter int HALF = sram_burst_pkg::K_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic kClk,
    input wire logic kClkN,
    input wire logic pllDisableN,
    input wire logic readPortSelectN,
    input wire logic writePortSelectN,
    input wire logic [AW-1:0] addr,
    input wire logic [sram_burst_pkg::WORD_W-1:0] q,
    input wire logic qOeN
);
    localparam int PLL_LO = 5 * HALF - 2;
    localparam int PLL_HI = 5 * HALF + 6;
    localparam int LEG_LO = 2 * HALF - 2;
    localparam int LEG_HI = 2 * HALF + 6;
    localparam int BURST_CLK = 4 * HALF;
    logic kPrev;
    logic rdAtLast;
    logic wrAtLast;
    logic [63:0] rdHist;
    logic [15:0] lowCnt;
    wire kRise = kClk & ~kPrev;
    wire rdStart = kRise & ~readPortSelectN;
    wire wrStart = kRise & ~writePortSelectN;
    wire [15:0] next_lowCnt = qOeN ? 16'h0 : lowCnt + 16'h1;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kPrev <= 1'h0;
            rdHist <= '0;
            lowCnt <= 16'h0;
        end else begin
            kPrev <= kClk;
            rdHist <= {rdHist[62:0], rdStart};
            lowCnt <= next_lowCnt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdAtLast <= 1'h0;
            wrAtLast <= 1'h0;
        end else if (kRise) begin
            rdAtLast <= rdStart;
            wrAtLast <= wrStart;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    clk_pair_a:
        assert property (kClkN == ~kClk)
        else $error("link clocks not complementary");
    k_half_a:
        assert property ($changed(kClk) |=>
            $stable(kClk) [*7] ##1 $changed(kClk))
        else $error("link clock half period wrong");
    sel_setup_a:
        assert property (kRise |-> $stable(readPortSelectN)
            && $stable(writePortSelectN) && $stable(addr))
        else $error("select or address moved at positive rise");
    rd_spacing_a:
        assert property (kRise && rdAtLast |-> readPortSelectN)
        else $error("read select repeated on next positive rise");
    wr_spacing_a:
        assert property (kRise && wrAtLast |-> writePortSelectN)
        else $error("write select repeated on next positive rise");
    one_cmd_a:
        assert property (kRise |-> readPortSelectN || writePortSelectN)
        else $error("both ports selected on one positive rise");
    burst_len_a:
        assert property ($rose(qOeN) |->
            lowCnt != 16'h0 && (lowCnt % BURST_CLK) == 0)
        else $error("read burst not whole four words");
    rd_latency_a:
        assert property ($fell(qOeN) |-> (pllDisableN ?
            |rdHist[PLL_HI:PLL_LO] : |rdHist[LEG_HI:LEG_LO]))
        else $error("first read word outside latency window");
    q_hold_a:
        assert property (!qOeN && $changed(q) |=> $stable(q) [*7])
        else $error("read word changed within half period");
    rd_answer_a:
        assert property (rdStart && pllDisableN |->
            ##[PLL_LO:PLL_HI] !qOeN)
        else $error("read not answered in latency window");
    leg_answer_a:
        assert property (rdStart && !pllDisableN |->
            ##[LEG_LO:LEG_HI] !qOeN)
        else $error("legacy read not answered in window");

    cover property (rdStart && pllDisableN);
    cover property (rdStart && !pllDisableN);
    cover property (wrStart);
    cover property ($rose(qOeN) && lowCnt > 16'(BURST_CLK));
endmodule

// File: dual_port_burst_sram_timing_tb.sv
// Self-checking bench for the burst SRAM controller and device pair
`timescale 1ns/1ns
module dual_port_burst_sram_timing_tb;
    localparam int HALF = sram_burst_pkg::K_HALF_CYCLES;
    localparam int AW = sram_burst_pkg::ADDR_W;
    localparam int BW = sram_burst_pkg::BURST_W;
    localparam int MW = sram_burst_pkg::MASK_W;
    localparam int BYW = sram_burst_pkg::BYTE_W;
    logic clk;
    logic nrst;
    logic reqValid;
    logic reqReady;
    logic reqWrite;
    logic [AW-1:0] reqAddr;
    logic [BW-1:0] reqData;
    logic [MW-1:0] reqMask;
    logic pllDisableN;
    logic rspValid;
    logic [BW-1:0] rspData;
    logic pllEnabled;
    logic [BW-1:0] shadow [8];
    logic [BW-1:0] expQ [$];
    logic [2:0] lastWr;
    int nErrors = 0;
    int testsRun = 0;

    sram_link_if #(.AW(AW)) sram_link_if_i ();
    burst_sram_ctrl #(.AW(AW), .HALF(HALF)) burst_sram_ctrl_i (
        .clk(clk), .nrst(nrst), .link(sram_link_if_i),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .reqMask(reqMask),
        .pllDisableN(pllDisableN), .rspValid(rspValid), .rspData(rspData)
    );
    burst_sram_device #(.AW(AW)) burst_sram_device_i (
        .clk(clk), .nrst(nrst), .link(sram_link_if_i),
        .pllEnabled(pllEnabled)
    );
    burst_sram_link_sva #(.AW(AW), .HALF(HALF)) burst_sram_link_sva_i (
        .clk(clk), .nrst(nrst), .kClk(sram_link_if_i.kClk),
        .kClkN(sram_link_if_i.kClkN),
        .pllDisableN(sram_link_if_i.pllDisableN),
        .readPortSelectN(sram_link_if_i.readPortSelectN),
        .writePortSelectN(sram_link_if_i.writePortSelectN),
        .addr(sram_link_if_i.addr), .q(sram_link_if_i.q),
        .qOeN(sram_link_if_i.qOeN)
    );

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    function automatic logic [BW-1:0] rnd();
        return BW'({$urandom, $urandom, $urandom});
    endfunction

    // Enabled bytes take new data, the rest keep the old
    function automatic logic [BW-1:0] merge(input logic [BW-1:0] old,
            input logic [BW-1:0] nw, input logic [MW-1:0] m);
        logic [BW-1:0] r;
        r = old;
        for (int j = 0; j < MW; j++) begin
            if (m[j]) begin
                r[j*BYW +: BYW] = nw[j*BYW +: BYW];
            end
        end
        return r;
    endfunction

    task automatic check(input string what, input logic [BW-1:0] exp,
            input logic [BW-1:0] got);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Entered at a falling edge; returns at the one after acceptance
    task automatic send(input logic wr, input logic [2:0] a,
            input logic [BW-1:0] dat, input logic [MW-1:0] m);
        int n;
        n = 0;
        reqValid = 1'h1;
        reqWrite = wr;
        reqAddr = AW'(a);
        reqData = dat;
        reqMask = m;
        while (reqReady !== 1'h1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000) begin
            nErrors++;
            $display("mismatch reqReady expected 1 seen %b", reqReady);
        end
        @(negedge clk);
        if (wr) begin
            shadow[a] = merge(shadow[a], dat, m);
            lastWr = a;
        end else begin
            expQ.push_back(shadow[a]);
        end
    endtask

    task automatic idle(input string name);
        int n;
        n = 0;
        reqValid = 1'h0;
        while (expQ.size() != 0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (expQ.size() != 0) begin
            nErrors++;
            $display("mismatch pending expected 0 seen %0d", expQ.size());
        end
        repeat (50) @(negedge clk);
        $display("test %s finished", name);
    endtask

    task automatic fill();
        int n;
        logic [BW-1:0] dat;
        n = 0;
        while (n < 40 && reqReady === 1'h1) begin
            dat = rnd();
            reqValid = 1'h1;
            reqWrite = 1'h1;
            reqAddr = AW'(n % 8);
            reqData = dat;
            reqMask = '1;
            @(negedge clk);
            shadow[n % 8] = dat;
            lastWr = 3'(n % 8);
            n++;
        end
        reqValid = 1'h0;
        testsRun++;
        if (n < sram_burst_pkg::FIFO_DEPTH || n >= 40) begin
            nErrors++;
            $display("mismatch fillCount expected %0d seen %0d",
                sram_burst_pkg::FIFO_DEPTH, n);
        end
        repeat (40) @(negedge clk);
        send(1'h0, lastWr + 3'h1, '0, '0);
        idle("fifo_fill");
    endtask

    task automatic rand_ops(input string name, input int cnt);
        logic wr;
        logic [2:0] a;
        for (int i = 0; i < cnt; i++) begin
            wr = 1'($urandom_range(1, 0));
            a = 3'($urandom_range(7, 0));
            if (!wr && a == lastWr) begin
                a = a + 3'h1;
            end
            send(wr, a, rnd(), MW'($urandom));
        end
        send(1'h0, lastWr + 3'h1, '0, '0);
        idle(name);
    endtask

    task automatic masks();
        for (int j = 0; j <= MW; j++) begin
            send(1'h1, 3'h5, rnd(), (j < MW) ? MW'(1 << j) : MW'(0));
            send(1'h0, 3'h6, '0, '0);
            send(1'h0, 3'h5, '0, '0);
        end
        idle("byte_masks");
    endtask

    always @(negedge clk) begin
        if (rspValid === 1'h1) begin
            if (expQ.size() == 0) begin
                nErrors++;
                $display("mismatch rspData expected none seen %h", rspData);
            end else begin
                check("rspData", expQ.pop_front(), rspData);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        $display("mismatch watchdog expected done seen hang");
        final_report();
    end

    initial begin
        nrst = 1'h0;
        reqValid = 1'h0;
        reqWrite = 1'h0;
        reqAddr = '0;
        reqData = '0;
        reqMask = '0;
        pllDisableN = 1'h1;
        lastWr = 3'h0;
        void'($urandom(26));
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst = 1'h1;
        repeat (6) @(negedge clk);
        check("pllEnabled", BW'(1), BW'(pllEnabled));
        check("qOeN", BW'(1), BW'(sram_link_if_i.qOeN));
        fill();
        rand_ops("random_pll_on", 60);
        masks();
        pllDisableN = 1'h0;
        repeat (20) @(negedge clk);
        check("pllEnabled", BW'(0), BW'(pllEnabled));
        rand_ops("random_legacy", 40);
        pllDisableN = 1'h1;
        repeat (20) @(negedge clk);
        check("pllEnabled", BW'(1), BW'(pllEnabled));
        rand_ops("random_pll_back", 16);
        final_report();
    end
endmodule
